/* common/ssie_pkg.sv */
// Shared constants and types for the encoder emulation block
package ssie_pkg;

  // Clock and link timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int RATE_MIN_KBPS = 200;
  localparam int RATE_MAX_KBPS = 1500;
  // Shortest half period of the link clock, in own clock cycles
  localparam int MIN_HALF_CYC = CLK_HZ / (2 * RATE_MAX_KBPS * 1000);
  localparam int MONO_US = 25;
  localparam int MONO_CYC = CYC_PER_US * MONO_US;
  localparam int READ_MIN_US = 125;
  localparam int CTRL_US = 125;
  localparam int CTRL_CYC = CYC_PER_US * CTRL_US;
  localparam int LOCK_TOL_CYC = 8;
  localparam int LOCK_FRAMES = 4;

  // Frame layout
  localparam int POS_BITS = 32;
  localparam int ST_RES_DEF = 20;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_MULTI = 4'h1;
  localparam logic [3:0] ADDR_SINGLE = 4'h2;
  localparam logic [3:0] ADDR_POLARITY = 4'h3;
  localparam logic [3:0] ADDR_PHASE = 4'h4;
  localparam logic [3:0] ADDR_PAR_EN = 4'h5;
  localparam logic [3:0] ADDR_PAR_KIND = 4'h6;
  localparam logic [3:0] ADDR_SYNC_EN = 4'h7;
  localparam logic [3:0] ADDR_LOCKED = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'h9;
  localparam logic [3:0] ADDR_FRAMES = 4'hA;

  // Values after reset
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_MULTI = 16'h000C;
  localparam logic [15:0] RST_SINGLE = 16'h0014;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // Parity kind encoding
  localparam logic PARITY_ODD = 1'b0;
  localparam logic PARITY_EVEN = 1'b1;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } ssie_state_t;

endpackage

/* hdl/ssie_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module ssie_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic level_q
);

  logic meta_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  // Level only moves once stages two and three agree
  always_comb begin
    level_d = level_q;
    if (s2_q == s3_q) begin
      level_d = s3_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      s2_q <= meta_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

endmodule

/* hdl/ssie_lock.sv */
// Control cycle timer that aligns to the master's read cycle
`timescale 1ns/100ps
module ssie_lock import ssie_pkg::*; #(
  parameter int PERIOD = CTRL_CYC,
  parameter int TOL = LOCK_TOL_CYC,
  parameter int FRAMES = LOCK_FRAMES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sync_en,
  input wire logic frame_start,
  output logic ctrl_tick_q,
  output logic locked_q
);

  if (PERIOD < 2 || PERIOD > 65535 || TOL >= PERIOD / 2 || FRAMES < 1 ||
      FRAMES > 15) begin : g_bad
    $error("ssie_lock: unsupported parameters");
  end

  localparam logic [15:0] LAST = 16'(PERIOD - 1);
  localparam logic [15:0] TOLW = 16'(TOL);
  localparam logic [3:0] GOODW = 4'(FRAMES);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [3:0] good_q;
  logic [3:0] good_d;
  logic tick_d;
  logic locked_d;
  logic near;

  always_comb begin
    cnt_d = (cnt_q == LAST) ? 16'h0000 : cnt_q + 16'h0001;
    tick_d = (cnt_q == LAST);
    good_d = good_q;
    near = (cnt_q <= TOLW) || (cnt_q >= LAST - TOLW);
    if (!sync_en) begin
      good_d = 4'h0;
    end else if (frame_start) begin
      if (near) begin
        if (good_q != GOODW) begin
          good_d = good_q + 4'h1;
        end
      end else begin
        // Hard realignment of the control cycle to the first edge
        good_d = 4'h0;
        cnt_d = 16'h0000;
        tick_d = 1'b1;
      end
    end
    locked_d = sync_en && (good_d == GOODW);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 16'h0000;
      good_q <= 4'h0;
      ctrl_tick_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      good_q <= good_d;
      ctrl_tick_q <= tick_d;
      locked_q <= locked_d;
    end
  end

endmodule

/* hdl/ssie_top.sv */
// Encoder emulation: serial absolute position slave with registers
//
// What this block does
// - Emulation runs only while the enable register holds 1.
// - Acts as absolute encoder slave, returning drive position per read.
// - Sends multi-turn bits then single-turn bits, plain binary.
// - Correct data at link rates from 200 to 1500 kbit/s.
// - Optional parity bit, odd or even by the parity kind setting.
// - Hold recovery about 25 us after last edge; master waits too.
// - Clock idle level low when polarity false, high when true.
// - Phase setting selects the edge that changes the data line.
// - Phase false drives on leading edge, true on following edge.
// - Parity bit follows directly after the least significant bit.
// - Position from a 32-bit source, at most 32 information bits.
// - With sync enabled, control cycle aligns to the read cycle.
// - Readable flag shows whether control cycle is locked.
`timescale 1ns/100ps
module ssie_top import ssie_pkg::*; #(
  parameter int POS_W = POS_BITS,
  parameter int ST_RES = ST_RES_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [31:0] pos_in,
  input wire logic ssi_clk,
  output logic ssi_data,
  output logic ssi_data_oe,
  output logic ctrl_tick,
  output logic cycle_locked
);

  // Sampling needs a few own cycles per link half period
  if (POS_W != POS_BITS || ST_RES < 1 || ST_RES > POS_W ||
      MIN_HALF_CYC < 4) begin : g_bad
    $error("ssie_top: unsupported parameters");
  end

  localparam logic [9:0] MONO_LAST = 10'(MONO_CYC - 1);

  // Register file
  logic [15:0] enable_q;
  logic [15:0] enable_d;
  logic [15:0] multi_q;
  logic [15:0] multi_d;
  logic [15:0] single_q;
  logic [15:0] single_d;
  logic [15:0] pol_q;
  logic [15:0] pol_d;
  logic [15:0] phase_q;
  logic [15:0] phase_d;
  logic [15:0] par_en_q;
  logic [15:0] par_en_d;
  logic [15:0] par_kind_q;
  logic [15:0] par_kind_d;
  logic [15:0] sync_en_q;
  logic [15:0] sync_en_d;
  logic [15:0] rdata_d;

  // Link side
  ssie_state_t state_q;
  ssie_state_t state_d;
  logic [5:0] idx_q;
  logic [5:0] idx_d;
  logic [9:0] mono_q;
  logic [9:0] mono_d;
  logic [31:0] pos_q;
  logic [31:0] pos_d;
  logic [15:0] frames_q;
  logic [15:0] frames_d;
  logic data_d;
  logic oe_d;
  logic start_q;
  logic start_d;
  logic sclk_lvl;
  logic sclk_prev_q;

  logic en;
  logic pol;
  logic edge_seen;
  logic lead;
  logic trail;
  logic chg;
  logic at_idle;
  logic [31:0] src;
  logic [5:0] k;
  logic out_bit;
  logic lock_tick;
  logic lock_flag;
  int m_eff;
  int s_eff;

  // Bit k of the frame body: multi-turn field above ST_RES, then single-turn
  function automatic logic frame_bit(input logic [31:0] pos, input int m,
                                     input int k);
    int idx;
    idx = (k < m) ? (ST_RES + m - 1 - k) : (ST_RES - 1 - (k - m));
    // Bits past the source read as zero, as on a short encoder
    if (idx < 0 || idx >= POS_W) begin
      return 1'b0;
    end
    return pos[idx];
  endfunction

  function automatic logic body_xor(input logic [31:0] pos, input int m,
                                    input int n);
    logic p;
    p = 1'b0;
    for (int i = 0; i < POS_BITS; i++) begin
      if (i < n) begin
        p = p ^ frame_bit(pos, m, i);
      end
    end
    return p;
  endfunction

  ssie_sync u_clk_sync (
    .clk(mclk),
    .reset_n(reset_n),
    .async_in(ssi_clk),
    .level_q(sclk_lvl)
  );

  ssie_lock #(
    .PERIOD(CTRL_CYC),
    .TOL(LOCK_TOL_CYC),
    .FRAMES(LOCK_FRAMES)
  ) u_lock (
    .clk(mclk),
    .reset_n(reset_n),
    .sync_en(sync_en_q[0] && en),
    .frame_start(start_q),
    .ctrl_tick_q(lock_tick),
    .locked_q(lock_flag)
  );

  assign ctrl_tick = lock_tick;
  assign cycle_locked = lock_flag;

  // Register writes and reads
  always_comb begin
    enable_d = enable_q;
    multi_d = multi_q;
    single_d = single_q;
    pol_d = pol_q;
    phase_d = phase_q;
    par_en_d = par_en_q;
    par_kind_d = par_kind_q;
    sync_en_d = sync_en_q;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_ENABLE: enable_d = reg_wdata;
        ADDR_MULTI: multi_d = reg_wdata;
        ADDR_SINGLE: single_d = reg_wdata;
        ADDR_POLARITY: pol_d = reg_wdata;
        ADDR_PHASE: phase_d = reg_wdata;
        ADDR_PAR_EN: par_en_d = reg_wdata;
        ADDR_PAR_KIND: par_kind_d = reg_wdata;
        ADDR_SYNC_EN: sync_en_d = reg_wdata;
        default: ;
      endcase
    end
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_ENABLE: rdata_d = enable_q;
        ADDR_MULTI: rdata_d = multi_q;
        ADDR_SINGLE: rdata_d = single_q;
        ADDR_POLARITY: rdata_d = pol_q;
        ADDR_PHASE: rdata_d = phase_q;
        ADDR_PAR_EN: rdata_d = par_en_q;
        ADDR_PAR_KIND: rdata_d = par_kind_q;
        ADDR_SYNC_EN: rdata_d = sync_en_q;
        ADDR_LOCKED: rdata_d = {15'h0000, lock_flag};
        ADDR_STATUS: rdata_d = {6'h00, state_q, 2'h0, idx_q};
        ADDR_FRAMES: rdata_d = frames_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= RST_ENABLE;
      multi_q <= RST_MULTI;
      single_q <= RST_SINGLE;
      pol_q <= RST_ZERO;
      phase_q <= RST_ZERO;
      par_en_q <= RST_ZERO;
      par_kind_q <= RST_ZERO;
      sync_en_q <= RST_ZERO;
      reg_rdata <= 16'h0000;
    end else begin
      enable_q <= enable_d;
      multi_q <= multi_d;
      single_q <= single_d;
      pol_q <= pol_d;
      phase_q <= phase_d;
      par_en_q <= par_en_d;
      par_kind_q <= par_kind_d;
      sync_en_q <= sync_en_d;
      reg_rdata <= rdata_d;
    end
  end

  // Link edge decode and frame bit selection
  always_comb begin
    en = (enable_q == 16'h0001);
    pol = pol_q[0];
    // Idle level follows polarity; leading edge leaves idle
    edge_seen = (sclk_lvl != sclk_prev_q);
    lead = edge_seen && (sclk_lvl != pol);
    trail = edge_seen && (sclk_lvl == pol);
    at_idle = (sclk_lvl == pol);
    chg = phase_q[0] ? trail : lead;
    // Counts clipped so that no more than 32 position bits are sent
    m_eff = (multi_q > 16'(POS_BITS)) ? POS_BITS : int'(multi_q);
    s_eff = (int'(single_q) > POS_BITS - m_eff) ? POS_BITS - m_eff :
            int'(single_q);
    // The idle cycle still sees the live source so bit 0 can leave at once
    src = (state_q == ST_IDLE) ? pos_in : pos_q;
    k = (state_q == ST_IDLE) ? 6'h00 : idx_q;
    if (int'(k) < m_eff + s_eff) begin
      out_bit = frame_bit(src, m_eff, int'(k));
    end else if ((int'(k) == m_eff + s_eff) && par_en_q[0]) begin
      // Even kind makes the total count of ones even
      out_bit = body_xor(src, m_eff, m_eff + s_eff) ^
                (par_kind_q[0] == PARITY_ODD);
    end else begin
      out_bit = 1'b0;
    end
  end

  // Frame sequencer
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    mono_d = mono_q;
    pos_d = pos_q;
    frames_d = frames_q;
    data_d = ssi_data;
    oe_d = ssi_data_oe;
    start_d = 1'b0;
    unique case (state_q)
      ST_OFF: begin
        oe_d = 1'b0;
        data_d = 1'b1;
        if (en) begin
          state_d = ST_IDLE;
          oe_d = 1'b1;
        end
      end
      ST_IDLE: begin
        data_d = 1'b1;
        if (lead) begin
          // First edge freezes the position for the whole frame
          pos_d = pos_in;
          start_d = 1'b1;
          frames_d = frames_q + 16'h0001;
          mono_d = 10'h000;
          state_d = ST_SHIFT;
          idx_d = 6'h00;
          data_d = 1'b0;
          if (!phase_q[0]) begin
            data_d = out_bit;
            idx_d = 6'h01;
          end
        end
      end
      ST_SHIFT: begin
        if (edge_seen) begin
          mono_d = 10'h000;
        end else if (mono_q != MONO_LAST) begin
          mono_d = mono_q + 10'h001;
        end
        if (chg) begin
          data_d = out_bit;
          if (idx_q != 6'h3F) begin
            idx_d = idx_q + 6'h01;
          end
        end
        // Recovery ends only after a quiet spell with the clock at rest
        if (!edge_seen && at_idle && mono_q == MONO_LAST) begin
          state_d = ST_IDLE;
          data_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (!en) begin
      // Disabling aborts any frame and releases the data line
      state_d = ST_OFF;
      oe_d = 1'b0;
      data_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_OFF;
      idx_q <= 6'h00;
      mono_q <= 10'h000;
      pos_q <= 32'h0000_0000;
      frames_q <= 16'h0000;
      ssi_data <= 1'b1;
      ssi_data_oe <= 1'b0;
      start_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      mono_q <= mono_d;
      pos_q <= pos_d;
      frames_q <= frames_d;
      ssi_data <= data_d;
      ssi_data_oe <= oe_d;
      start_q <= start_d;
      sclk_prev_q <= sclk_lvl;
    end
  end

endmodule

/* verif/ssie_top_properties.sv */
// Port checks for the encoder emulation block
`timescale 1ns/100ps
module ssie_checker import ssie_pkg::*; #(
  parameter int POS_W = POS_BITS,
  parameter int ST_RES = ST_RES_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [31:0] pos_in,
  input wire logic ssi_clk,
  input wire logic ssi_data,
  input wire logic ssi_data_oe,
  input wire logic ctrl_tick,
  input wire logic cycle_locked
);
  logic en_q;
  logic sync_q;
  logic [15:0] mt_q;
  logic [15:0] st_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Shadow of the enable, sync, multi-turn and single-turn settings, kept apart from the design
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      sync_q <= 1'b0;
      mt_q <= RST_MULTI;
      st_q <= RST_SINGLE;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_ENABLE) en_q <= (reg_wdata == 16'h0001);
      if (reg_addr == ADDR_SYNC_EN) sync_q <= reg_wdata[0];
      if (reg_addr == ADDR_MULTI) mt_q <= reg_wdata;
      if (reg_addr == ADDR_SINGLE) st_q <= reg_wdata;
    end
  end
  rdata_rest_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("Stray rdata");
  lock_read_a: assert property (
    reg_rd && reg_addr == ADDR_LOCKED |=>
    reg_rdata == {15'h0000, $past(cycle_locked)}) else $error("Lock read");
  off_quiet_a: assert property (
    !en_q && !$past(en_q) |-> !ssi_data_oe && ssi_data)
    else $error("Output active while off");
  tick_pulse_a: assert property (
    ctrl_tick |=> !ctrl_tick [*8]) else $error("Ticks too close");
  lock_sync_a: assert property (
    $rose(cycle_locked) |-> sync_q && en_q) else $error("Lock without sync");
  lock_off_a: assert property (
    !sync_q [*3] |-> !cycle_locked) else $error("Lock kept without sync");
  multi_read_a: assert property (
    reg_rd && reg_addr == ADDR_MULTI |=> reg_rdata == $past(mt_q))
    else $error("Multi-turn count read");
  single_read_a: assert property (
    reg_rd && reg_addr == ADDR_SINGLE |=> reg_rdata == $past(st_q))
    else $error("Single-turn count read");
  cover property ($rose(cycle_locked));
  cover property ($fell(cycle_locked));
  cover property ($rose(ssi_data_oe));
endmodule
bind ssie_top ssie_checker #(.POS_W(POS_W), .ST_RES(ST_RES)) u_ssie_checker (
  .mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .pos_in, .ssi_clk, .ssi_data, .ssi_data_oe, .ctrl_tick, .cycle_locked);

/* verif/ssie_master_model.sv */
// Behavioural link master that clocks position frames out of the block
`timescale 1ns/100ps
module ssie_master_model (
  output logic link_clk,
  input wire logic data_in
);
  initial link_clk = 1'b0;
  // Moved only while the block is off, else it would look like an edge
  task automatic set_idle(input logic pol);
    link_clk = pol;
  endtask
  // One edge pair per bit; bit read just before the next edge
  task automatic frame(input int n, input logic pol, input logic ph,
      input int half, output logic [63:0] got);
    int i;
    got = '0;
    for (i = 0; i < n; i++) begin
      #(half);
      if (ph && i > 0) got = {got[62:0], data_in};
      link_clk = !pol;
      #(half);
      if (!ph) got = {got[62:0], data_in};
      link_clk = pol;
    end
    if (ph) begin
      #(half);
      got = {got[62:0], data_in};
    end
  endtask
endmodule

/* verif/test_ssie_top.sv */
// Self-checking bench for the encoder emulation block
`timescale 1ns/100ps
module test_ssie_top import ssie_pkg::*;;
  logic mclk;
  logic reset_n;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [31:0] pos_in;
  logic ssi_clk;
  logic ssi_data;
  logic ssi_data_oe;
  logic ctrl_tick;
  logic cycle_locked;
  logic line;
  logic [63:0] got;
  logic [15:0] rv;
  int n_fail;
  int total_checks;
  int i;
  int n_tick;
  int t0;
  // Released line rests high through its terminating pull-up
  assign line = ssi_data_oe ? ssi_data : 1'b1;
  ssie_top u_ssie_top (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pos_in(pos_in), .ssi_clk(ssi_clk),
    .ssi_data(ssi_data), .ssi_data_oe(ssi_data_oe), .ctrl_tick(ctrl_tick),
    .cycle_locked(cycle_locked));
  ssie_master_model u_ssie_master_model (.link_clk(ssi_clk), .data_in(line));
  always #20 mclk = ~mclk;
  // Ticks are counted at the edge, so a window of edges holds whole periods
  always @(posedge mclk) begin
    if (ctrl_tick === 1'b1) n_tick++;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [63:0] exp_frame(logic [31:0] p, int m, int s,
      logic pe, logic ev);
    logic [63:0] f;
    logic x;
    int k;
    f = '0;
    x = 1'b0;
    for (k = ST_RES_DEF + m - 1; k >= ST_RES_DEF - s; k--) begin
      f = {f[62:0], (k >= 0 && k < 32) ? p[k] : 1'b0};
      x ^= f[0];
    end
    if (pe) f = {f[62:0], ev ? x : ~x};
    return f;
  endfunction
  // Settings change only while off, so the idle level move is ignored
  task automatic run(input logic p, ph, input int m, s, input logic pe, ev,
      input int half, input logic [31:0] pos);
    logic [63:0] g;
    int mc;
    int sc;
    // Counts past 32 bits in all are clipped by the block
    mc = (m > POS_BITS) ? POS_BITS : m;
    sc = (s > POS_BITS - mc) ? POS_BITS - mc : s;
    wr(ADDR_ENABLE, 16'h0000);
    u_ssie_master_model.set_idle(p);
    wr(ADDR_POLARITY, {15'h0000, p});
    wr(ADDR_PHASE, {15'h0000, ph});
    wr(ADDR_MULTI, 16'(m));
    wr(ADDR_SINGLE, 16'(s));
    wr(ADDR_PAR_EN, {15'h0000, pe});
    wr(ADDR_PAR_KIND, {15'h0000, ev});
    wr(ADDR_ENABLE, 16'h0001);
    repeat (8) @(posedge mclk);
    pos_in <= pos;
    fork
      u_ssie_master_model.frame(mc + sc + int'(pe), p, ph, half, g);
      begin
        #(half * 3);
        @(posedge mclk);
        pos_in <= ~pos;
      end
    join
    check(g, exp_frame(pos, mc, sc, pe, ev));
    #30_000;
    check(64'(line), 64'h1);
    #100_000;
    $display("Frame test m=%0d s=%0d done", m, s);
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    n_fail++;
    stop_test;
  end
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pos_in = 32'h0000_0000;
    n_fail = 0;
    total_checks = 0;
    n_tick = 0;
    t0 = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    for (i = 0; i < 11; i++) begin
      rd(4'(i), rv);
      check(64'(rv), (i == 1) ? 64'(RST_MULTI) : (i == 2) ? 64'(RST_SINGLE)
        : 64'h0);
    end
    wr(ADDR_LOCKED, 16'h0001);
    rd(ADDR_LOCKED, rv);
    check(64'(rv), 64'h0);
    rd(4'hF, rv);
    check(64'(rv), 64'h0);
    u_ssie_master_model.frame(8, 1'b0, 1'b0, 334, got);
    check(got, 64'hFF);
    wr(ADDR_ENABLE, 16'h0002);
    rd(ADDR_ENABLE, rv);
    check(64'(rv), 64'h2);
    u_ssie_master_model.frame(8, 1'b0, 1'b0, 334, got);
    check(got, 64'hFF);
    #130_000;
    $display("Register and off tests done");
    run(0, 0, 12, 20, 0, 0, 334, 32'h89AB_CDEF);
    run(0, 0, 40, 9, 0, 0, 334, 32'h8000_0001);
    run(1, 0, 4, 8, 1, 1, 2500, 32'h1234_5678);
    run(0, 1, 3, 5, 1, 0, 334, 32'hFFF5_A5A5);
    run(1, 1, 12, 20, 0, 0, 2500, 32'h0F0F_3C3C);
    // A read inside the recovery time only yields further zero bits
    u_ssie_master_model.frame(32, 1'b1, 1'b1, 334, got);
    #15_000;
    u_ssie_master_model.frame(8, 1'b1, 1'b1, 334, got);
    check(got, 64'h0);
    #30_000;
    check(64'(line), 64'h1);
    // Late edges only stretched the frame: still one start per frame
    rd(ADDR_STATUS, rv);
    check(64'(rv), 64'h0128);
    rd(ADDR_FRAMES, rv);
    check(64'(rv), 64'h6);
    #100_000;
    $display("Recovery test done");
    wr(ADDR_SYNC_EN, 16'h0001);
    for (i = 0; i < 6; i++) begin
      fork
        u_ssie_master_model.frame(32, 1'b1, 1'b1, 334, got);
        #125_000;
      join
    end
    rd(ADDR_LOCKED, rv);
    check(64'(rv), 64'h1);
    check(64'(cycle_locked), 64'h1);
    #15_000;
    u_ssie_master_model.frame(32, 1'b1, 1'b1, 334, got);
    rd(ADDR_LOCKED, rv);
    check(64'(rv), 64'h0);
    check(64'(cycle_locked), 64'h0);
    wr(ADDR_SYNC_EN, 16'h0000);
    // Free-running control cycle ticks once in every period
    @(posedge mclk);
    #1 t0 = n_tick;
    repeat (CTRL_CYC) @(posedge mclk);
    #1 check(64'(n_tick - t0), 64'h1);
    #5_000;
    $display("Sync test done");
    stop_test;
  end
endmodule
